// ### hdl/dbmis_seq.sv
// Bus control interface unit core: remote-mode responder and master-mode list sequencer.
// Assumes word-level transceivers, a DMA read port and processor streams on core_clk.
// How it works
// RQ1 - One processor is joined to two serial buses with a port set per bus.
// RQ2 - Processor picks the mode and starts it; the unit runs only in that mode.
// RQ3 - Remote mode moves data words both ways between processor and addressed bus.
// RQ4 - Remote mode answers an accepted command with status on the same bus.
// RQ5 - Remote mode flags special commands and interrupts the processor.
// RQ6 - Master mode fetches its instructions from processor memory by DMA.
// RQ7 - Master mode sends commands to other terminals on the buses.
// RQ8 - Master mode sends or takes data itself when named in the instruction.
// RQ9 - Master mode checks every status reply it receives.
// RQ10 - Master mode checks word sync and sequence of each bus operation.
// RQ11 - Master mode reports detected errors in the status word.
// RQ12 - Software keeps only one unit on the bus system in master mode.
// RQ13 - Instructions are read as sixteen-bit word pairs and run in order.
// RQ14 - A two-bit operation field chooses the action.
// RQ15 - Halt code stops list processing.
// RQ16 - Halt sets the halt flag and raises the level one interrupt.
// RQ17 - Link code takes word two as the next pair's address.
// RQ18 - Link ignores every field but the completion interrupt flag.
// RQ19 - Flagged successful instructions set the programmed interrupt flag.
// RQ20 - Bus operation code runs a receive or transmit on the chosen bus.
// RQ21 - After halt no fetch happens until the processor starts again.
`timescale 1ns/1ns
`default_nettype none
`include "dbmis_params.svh"
module dbmis_seq (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic master_sel,
    input wire logic go_start,
    input wire logic go_stop,
    input wire logic [15:0] list_addr,
    input wire logic [4:0] own_addr,
    output logic dma_req_valid,
    input wire logic dma_req_ready,
    output logic [15:0] dma_req_addr,
    input wire logic dma_rsp_valid,
    input wire logic [15:0] dma_rsp_data,
    output logic [1:0] bus_tx_valid,
    input wire logic [1:0] bus_tx_ready,
    output dbmis_pkg::dbmis_word_s [1:0] bus_tx_word,
    input wire logic [1:0] bus_rx_valid,
    output logic [1:0] bus_rx_ready,
    input wire dbmis_pkg::dbmis_word_s [1:0] bus_rx_word,
    output logic proc_rx_valid,
    input wire logic proc_rx_ready,
    output logic [15:0] proc_rx_data,
    input wire logic proc_tx_valid,
    output logic proc_tx_ready,
    input wire logic [15:0] proc_tx_data,
    input wire logic [15:0] isw_clr,
    output logic [15:0] internal_status_word,
    output logic irq_lvl1,
    output logic running
);
    dbmis_pkg::dbmis_state_e state_q, state_d;
    dbmis_pkg::dbmis_iw1_s iw1_q;
    dbmis_pkg::dbmis_iw2_s iw2_q;
    dbmis_pkg::dbmis_cmd_s rcmd_q, rx_cmd;
    dbmis_pkg::dbmis_word_s tx_q, push_w, rx_w;
    logic running_q, cur_bus_q, tx_valid_q, rx_sel, rx_v, rx_take, push, word_done;
    logic load_cnt, buf_push, buf_pop, buf_in_ready, timeout, last, own_rx, own_tx;
    logic mode_cmd, halt_evt, buf_wr_q, buf_rd_q;
    logic [15:0] ptr_q, isw_q, isw_set, fail_q, fail_d;
    logic [5:0] cnt_q, cnt_src;
    logic [1:0] retry_q, buf_cnt_q;
    logic [10:0] tmo_q;
    logic [15:0] buf_q [2];

    // An idle remote unit listens on both buses, first bus winning a tie.
    assign rx_sel = (state_q == dbmis_pkg::S_IDLE) ? !bus_rx_valid[0] : cur_bus_q;
    assign rx_v = bus_rx_valid[rx_sel];
    assign rx_w = bus_rx_word[rx_sel];
    assign rx_cmd = rx_w.data;
    assign own_rx = iw1_q.raddr == own_addr;
    assign own_tx = iw2_q.taddr == own_addr;
    assign mode_cmd = iw1_q.rsa == `DBMIS_SA_MODE_LO && iw2_q.tsa == `DBMIS_SA_MODE_LO;
    assign last = cnt_q == 6'h01;
    assign timeout = tmo_q == 11'(`DBMIS_RESP_TO_CYC - 1);
    assign buf_in_ready = buf_cnt_q != 2'h2;
    assign halt_evt = state_q == dbmis_pkg::S_DECODE && iw1_q.op == `DBMIS_OP_HALT;
    assign dma_req_addr = ptr_q;
    assign running = running_q;
    assign internal_status_word = isw_q;
    assign irq_lvl1 = |isw_q; // RQ16 RQ19

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bus
            assign bus_tx_valid[gi] = tx_valid_q && cur_bus_q == gi; // RQ1
            assign bus_tx_word[gi] = tx_q;
            assign bus_rx_ready[gi] = (rx_sel == gi) ? rx_take : (state_q != dbmis_pkg::S_IDLE);
        end
    endgenerate

    always_comb begin
        state_d = state_q;
        rx_take = 1'b0;
        push = 1'b0;
        push_w = '0;
        word_done = 1'b0;
        load_cnt = 1'b0;
        cnt_src = iw2_q.wc == 5'h00 ? `DBMIS_WC_FULL : {1'b0, iw2_q.wc};
        buf_push = 1'b0;
        isw_set = '0;
        fail_d = '0;
        dma_req_valid = 1'b0;
        proc_tx_ready = 1'b0;
        case (state_q)
            dbmis_pkg::S_IDLE: begin
                if (running_q && master_sel) begin
                    state_d = dbmis_pkg::S_FETCH1;
                end else if (running_q && rx_v) begin
                    rx_take = 1'b1;
                    cnt_src = rx_cmd.wc == 5'h00 ? `DBMIS_WC_FULL : {1'b0, rx_cmd.wc};
                    if (rx_w.cmd_sync && rx_cmd.addr == own_addr) begin
                        load_cnt = 1'b1;
                        if (rx_cmd.sa == `DBMIS_SA_MODE_LO || rx_cmd.sa == `DBMIS_SA_MODE_HI) begin
                            isw_set[`DBMIS_ISW_SPECIAL] = 1'b1; // RQ5
                            state_d = dbmis_pkg::S_R_STAT;
                        end else if (!rx_cmd.tr) begin
                            state_d = dbmis_pkg::S_R_RXD; // RQ3
                        end else begin
                            state_d = dbmis_pkg::S_R_STAT;
                        end
                    end
                end
            end
            dbmis_pkg::S_FETCH1, dbmis_pkg::S_FETCH2: begin
                dma_req_valid = running_q; // RQ6 RQ13
                if (dma_req_ready && running_q) begin
                    state_d = state_q == dbmis_pkg::S_FETCH1 ? dbmis_pkg::S_WAIT1 : dbmis_pkg::S_WAIT2;
                end
            end
            dbmis_pkg::S_WAIT1: begin
                if (dma_rsp_valid) begin
                    state_d = dbmis_pkg::S_FETCH2;
                end
            end
            dbmis_pkg::S_WAIT2: begin
                if (dma_rsp_valid) begin
                    state_d = dbmis_pkg::S_DECODE;
                end
            end
            dbmis_pkg::S_DECODE: begin
                case (iw1_q.op) // RQ14
                    `DBMIS_OP_HALT: begin
                        isw_set[`DBMIS_ISW_HALT] = 1'b1; // RQ15 RQ16
                        state_d = dbmis_pkg::S_IDLE;
                    end
                    `DBMIS_OP_BUSOP: begin
                        if (iw1_q.raddr == iw2_q.taddr) begin
                            isw_set[`DBMIS_ISW_IVI] = 1'b1; // RQ11
                            state_d = dbmis_pkg::S_FETCH1;
                        end else begin
                            load_cnt = 1'b1;
                            state_d = dbmis_pkg::S_RCMD; // RQ20
                        end
                    end
                    default: state_d = dbmis_pkg::S_DONE; // RQ18
                endcase
            end
            dbmis_pkg::S_RCMD: begin
                if (own_rx) begin
                    state_d = dbmis_pkg::S_TCMD;
                end else if (!tx_valid_q) begin
                    push = 1'b1; // RQ7
                    push_w = {1'b1, iw1_q.raddr, 1'b0, iw1_q.rsa, iw2_q.wc};
                    state_d = dbmis_pkg::S_TCMD;
                end
            end
            dbmis_pkg::S_TCMD: begin
                if (own_tx) begin
                    state_d = dbmis_pkg::S_TXD; // RQ8
                end else if (!tx_valid_q) begin
                    push = 1'b1; // RQ7
                    push_w = {1'b1, iw2_q.taddr, 1'b1, iw2_q.tsa, iw2_q.wc};
                    state_d = dbmis_pkg::S_TSTAT;
                end
            end
            dbmis_pkg::S_TXD, dbmis_pkg::S_R_TXD: begin
                if (!tx_valid_q && proc_tx_valid) begin
                    proc_tx_ready = 1'b1; // RQ3 RQ8
                    push = 1'b1;
                    push_w = {1'b0, proc_tx_data};
                    word_done = 1'b1;
                    if (last) begin
                        state_d = state_q == dbmis_pkg::S_TXD ? dbmis_pkg::S_RSTAT : dbmis_pkg::S_IDLE;
                    end
                end
            end
            dbmis_pkg::S_TSTAT, dbmis_pkg::S_RSTAT: begin
                if (rx_v) begin
                    rx_take = 1'b1;
                    if (!rx_w.cmd_sync) begin
                        fail_d[`DBMIS_ISW_FORMAT] = 1'b1; // RQ10
                    end else if (rx_cmd.addr != (state_q == dbmis_pkg::S_TSTAT ?
                                                 iw2_q.taddr : iw1_q.raddr)) begin
                        fail_d[`DBMIS_ISW_BADSTAT] = 1'b1; // RQ9
                    end else if (state_q == dbmis_pkg::S_RSTAT || mode_cmd) begin
                        state_d = dbmis_pkg::S_DONE;
                    end else begin
                        state_d = dbmis_pkg::S_RXD;
                    end
                end else if (timeout) begin
                    fail_d[`DBMIS_ISW_NORESP] = 1'b1; // RQ9
                end
                if (fail_d != 16'h0000) begin
                    state_d = dbmis_pkg::S_FAIL;
                end
            end
            dbmis_pkg::S_RXD, dbmis_pkg::S_R_RXD: begin
                if (rx_v && rx_w.cmd_sync) begin
                    rx_take = 1'b1;
                    fail_d[`DBMIS_ISW_FORMAT] = 1'b1; // RQ10
                end else if (rx_v && (buf_in_ready || (state_q == dbmis_pkg::S_RXD && !own_rx))) begin
                    rx_take = 1'b1;
                    buf_push = state_q == dbmis_pkg::S_R_RXD || own_rx; // RQ3 RQ8
                    word_done = 1'b1;
                    if (last && state_q == dbmis_pkg::S_R_RXD) begin
                        state_d = dbmis_pkg::S_R_STAT;
                    end else if (last) begin
                        state_d = own_rx ? dbmis_pkg::S_DONE : dbmis_pkg::S_RSTAT;
                    end
                end else if (timeout && !rx_v) begin
                    fail_d[`DBMIS_ISW_NORESP] = 1'b1;
                end
                if (fail_d != 16'h0000) begin
                    if (state_q == dbmis_pkg::S_R_RXD) begin
                        isw_set = fail_d;
                        state_d = dbmis_pkg::S_IDLE;
                    end else begin
                        state_d = dbmis_pkg::S_FAIL;
                    end
                end
            end
            dbmis_pkg::S_R_STAT: begin
                if (!tx_valid_q) begin
                    push = 1'b1; // RQ4
                    push_w = {1'b1, own_addr, 11'h000};
                    state_d = (rcmd_q.tr && rcmd_q.sa != `DBMIS_SA_MODE_LO &&
                               rcmd_q.sa != `DBMIS_SA_MODE_HI) ? dbmis_pkg::S_R_TXD : dbmis_pkg::S_IDLE;
                end
            end
            dbmis_pkg::S_FAIL: begin
                if (retry_q != 2'h0) begin
                    load_cnt = 1'b1;
                    state_d = dbmis_pkg::S_RCMD;
                end else begin
                    isw_set = fail_q; // RQ11
                    state_d = dbmis_pkg::S_FETCH1;
                end
            end
            dbmis_pkg::S_DONE: begin
                isw_set[`DBMIS_ISW_PCI] = iw1_q.irq; // RQ19
                state_d = dbmis_pkg::S_FETCH1; // RQ13
            end
            default: state_d = dbmis_pkg::S_IDLE;
        endcase
        // A mode change or stop abandons the work at once rather than finish in the wrong mode.
        if (state_q != dbmis_pkg::S_IDLE && (!running_q || master_sel != (state_q < dbmis_pkg::S_R_RXD))) begin
            state_d = dbmis_pkg::S_IDLE; // RQ2
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= dbmis_pkg::S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            running_q <= 1'b0;
        end else if (go_start) begin
            running_q <= 1'b1;
        end else if (go_stop || halt_evt) begin
            running_q <= 1'b0; // RQ21
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr_q <= `DBMIS_PTR_RESET;
            iw1_q <= '0;
            iw2_q <= '0;
        end else if (go_start && master_sel) begin
            ptr_q <= list_addr;
        end else if (state_q == dbmis_pkg::S_WAIT1 && dma_rsp_valid) begin
            iw1_q <= dma_rsp_data; // RQ13
            ptr_q <= ptr_q + 16'h0001;
        end else if (state_q == dbmis_pkg::S_WAIT2 && dma_rsp_valid) begin
            iw2_q <= dma_rsp_data;
            ptr_q <= ptr_q + 16'h0001;
        end else if (state_q == dbmis_pkg::S_DECODE && iw1_q.op == `DBMIS_OP_LINK) begin
            ptr_q <= iw2_q; // RQ17
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 6'h00;
            retry_q <= 2'h0;
            fail_q <= 16'h0000;
            rcmd_q <= '0;
            cur_bus_q <= 1'b0;
        end else begin
            if (load_cnt) begin
                cnt_q <= cnt_src;
            end else if (word_done) begin
                cnt_q <= cnt_q - 6'h01;
            end
            if (state_q == dbmis_pkg::S_DECODE) begin
                retry_q <= iw1_q.retry;
                cur_bus_q <= iw2_q.bus; // RQ20
            end else if (state_q == dbmis_pkg::S_FAIL && retry_q != 2'h0) begin
                retry_q <= retry_q - 2'h1;
            end
            if (state_d == dbmis_pkg::S_FAIL && state_q != dbmis_pkg::S_FAIL) begin
                fail_q <= fail_d;
            end
            if (state_q == dbmis_pkg::S_IDLE && load_cnt) begin
                rcmd_q <= rx_cmd;
                cur_bus_q <= rx_sel; // RQ4
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmo_q <= 11'h000;
        end else if (state_d != state_q || rx_take) begin
            tmo_q <= 11'h000;
        end else if (!timeout) begin
            tmo_q <= tmo_q + 11'h001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_q <= '0;
            tx_valid_q <= 1'b0;
        end else if (push) begin
            tx_q <= push_w;
            tx_valid_q <= 1'b1;
        end else if (bus_tx_valid[cur_bus_q] && bus_tx_ready[cur_bus_q]) begin
            tx_valid_q <= 1'b0;
        end
    end

    // Setting wins over a clear in the same cycle so no event is lost.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            isw_q <= `DBMIS_ISW_RESET;
        end else begin
            isw_q <= isw_set | (isw_q & ~isw_clr); // RQ11 RQ16
        end
    end

    // Two entries let a stalled processor hold back the bus without dropping a word.
    assign buf_pop = proc_rx_valid && proc_rx_ready;
    assign proc_rx_valid = buf_cnt_q != 2'h0;
    assign proc_rx_data = buf_q[buf_rd_q];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buf_q[0] <= 16'h0000;
            buf_q[1] <= 16'h0000;
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_q[buf_wr_q] <= rx_w.data; // RQ3
                buf_wr_q <= !buf_wr_q;
            end
            if (buf_pop) begin
                buf_rd_q <= !buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_halt;
        halt_evt |=> isw_q[`DBMIS_ISW_HALT] && !running_q && state_q == dbmis_pkg::S_IDLE;
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop and flag"); // RQ16
    property p_no_fetch;
        !running_q |=> state_q == dbmis_pkg::S_IDLE && !dma_req_valid;
    endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("fetch while stopped"); // RQ21
    property p_link;
        state_q == dbmis_pkg::S_DECODE && iw1_q.op == `DBMIS_OP_LINK && !go_start
            |=> ptr_q == $past(iw2_q);
    endproperty
    a_link: assert property (p_link) else $error("link pointer wrong"); // RQ17
    property p_pci;
        state_q == dbmis_pkg::S_DECODE && iw1_q.op == `DBMIS_OP_LINK && iw1_q.irq && running_q
            && master_sel && !go_stop |-> ##2 isw_q[`DBMIS_ISW_PCI] && irq_lvl1;
    endproperty
    a_pci: assert property (p_pci) else $error("link interrupt missing"); // RQ19
    property p_pair;
        state_q == dbmis_pkg::S_WAIT2 && dma_rsp_valid && running_q && master_sel && !go_start
            |=> state_q == dbmis_pkg::S_DECODE && iw2_q == $past(dma_rsp_data);
    endproperty
    a_pair: assert property (p_pair) else $error("second word not latched"); // RQ13
    property p_ivi;
        state_q == dbmis_pkg::S_DECODE && iw1_q.op == `DBMIS_OP_BUSOP
            && iw1_q.raddr == iw2_q.taddr |=> isw_q[`DBMIS_ISW_IVI];
    endproperty
    a_ivi: assert property (p_ivi) else $error("same address not flagged"); // RQ11
    property p_reply;
        state_q == dbmis_pkg::S_R_STAT && !tx_valid_q |=> tx_valid_q && tx_q.cmd_sync
            && tx_q.data[15:11] == $past(own_addr) && cur_bus_q == $past(cur_bus_q);
    endproperty
    a_reply: assert property (p_reply) else $error("status reply wrong"); // RQ4
    property p_noresp;
        state_q == dbmis_pkg::S_TSTAT && timeout && !rx_v && running_q && master_sel
            |=> state_q == dbmis_pkg::S_FAIL;
    endproperty
    a_noresp: assert property (p_noresp) else $error("missing status not caught"); // RQ9
    property p_bus_sel;
        tx_valid_q |-> bus_tx_valid == (2'b01 << cur_bus_q);
    endproperty
    a_bus_sel: assert property (p_bus_sel) else $error("wrong bus driven"); // RQ1
    property p_mode;
        master_sel |=> !(state_q inside {dbmis_pkg::S_R_RXD, dbmis_pkg::S_R_TXD})
            || !$past(master_sel);
    endproperty
    a_mode: assert property (p_mode) else $error("remote work in master mode"); // RQ2
endmodule : dbmis_seq
`default_nettype wire

// ### hdl/dbmis_params.svh
// Constants of the dual bus instruction sequencer: codes, field values, status bits, timing.
// Assumes a 100 MHz core clock and sixteen-bit bus and memory words.
`ifndef DBMIS_PARAMS_SVH
`define DBMIS_PARAMS_SVH
`define DBMIS_CLK_MHZ 100
`define DBMIS_RESP_TO_NS 14000
`define DBMIS_RESP_TO_CYC ((`DBMIS_RESP_TO_NS * `DBMIS_CLK_MHZ) / 1000)
`define DBMIS_OP_HALT 2'h0
`define DBMIS_OP_LINK 2'h1
`define DBMIS_OP_NOP 2'h2
`define DBMIS_OP_BUSOP 2'h3
`define DBMIS_ISW_HALT 0
`define DBMIS_ISW_PCI 1
`define DBMIS_ISW_IVI 2
`define DBMIS_ISW_NORESP 3
`define DBMIS_ISW_BADSTAT 4
`define DBMIS_ISW_FORMAT 5
`define DBMIS_ISW_SPECIAL 6
`define DBMIS_ISW_RESET 16'h0000
`define DBMIS_PTR_RESET 16'h0000
`define DBMIS_SA_MODE_LO 5'h00
`define DBMIS_SA_MODE_HI 5'h1F
`define DBMIS_WC_FULL 6'h20
`endif

// ### hdl/dbmis_pkg.sv
// Types of the dual bus instruction sequencer: states, instruction words, bus words.
// Assumes the constants header is included by every user of these types.
package dbmis_pkg;
    typedef enum {
        S_IDLE, S_FETCH1, S_WAIT1, S_FETCH2, S_WAIT2, S_DECODE, S_RCMD, S_TCMD,
        S_TXD, S_TSTAT, S_RXD, S_RSTAT, S_DONE, S_FAIL, S_R_RXD, S_R_STAT, S_R_TXD
    } dbmis_state_e;
    typedef struct packed {
        logic [1:0] op;
        logic [1:0] retry;
        logic spare;
        logic irq;
        logic [4:0] raddr;
        logic [4:0] rsa;
    } dbmis_iw1_s;
    typedef struct packed {
        logic [4:0] wc;
        logic bus;
        logic [4:0] taddr;
        logic [4:0] tsa;
    } dbmis_iw2_s;
    typedef struct packed {
        logic [4:0] addr;
        logic tr;
        logic [4:0] sa;
        logic [4:0] wc;
    } dbmis_cmd_s;
    typedef struct packed {
        logic cmd_sync;
        logic [15:0] data;
    } dbmis_word_s;
endpackage : dbmis_pkg

// ### tb/dbmis_dma_mem.sv
// Partner model: processor memory behind the DMA read channel.
// Assumes one outstanding read; answer delay set by lat.
`timescale 1ns/1ns
`default_nettype none
module dbmis_dma_mem (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dma_req_valid,
    output logic dma_req_ready,
    input wire logic [15:0] dma_req_addr,
    output logic dma_rsp_valid,
    output logic [15:0] dma_rsp_data,
    input wire logic [3:0] lat
);
    logic [15:0] mem [0:255];
    logic [15:0] addr_log [$];
    logic [15:0] addr_q;
    logic busy_q;
    int wait_q;
    // Only one read is open at a time, so ready drops while busy.
    assign dma_req_ready = !busy_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            dma_rsp_valid <= 1'b0;
            dma_rsp_data <= 16'h0000;
        end else begin
            dma_rsp_valid <= 1'b0;
            // Outside a response the data lines churn so a stale word never looks valid.
            dma_rsp_data <= ~dma_rsp_data;
            if (busy_q && wait_q == 0) begin
                dma_rsp_valid <= 1'b1;
                dma_rsp_data <= mem[addr_q[7:0]];
                busy_q <= 1'b0;
            end else if (busy_q) begin
                wait_q <= wait_q - 1;
            end else if (dma_req_valid) begin
                busy_q <= 1'b1;
                wait_q <= lat;
                addr_q <= dma_req_addr;
                addr_log.push_back(dma_req_addr);
            end
        end
    end
endmodule : dbmis_dma_mem
`default_nettype wire

// ### tb/test_dual_bus_master_instruction_sequencer.sv
// Self-checking bench for the instruction sequencer with a DMA memory partner.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_dual_bus_master_instruction_sequencer;
    logic core_clk, rst, master_sel, go_start, go_stop, dma_req_valid, dma_req_ready;
    logic dma_rsp_valid, running, irq_lvl1, proc_rx_valid, proc_tx_ready, tx_seen;
    logic [15:0] list_addr, dma_req_addr, dma_rsp_data, isw_clr, internal_status_word;
    logic [15:0] proc_rx_data;
    logic [4:0] own_addr;
    logic [3:0] lat;
    logic [1:0] bus_tx_valid, bus_tx_ready, bus_rx_valid, bus_rx_ready;
    dbmis_pkg::dbmis_word_s [1:0] bus_tx_word, bus_rx_word;
    int miscompares, total_checks, cyc;
    dbmis_seq i_dbmis_seq (.core_clk(core_clk), .rst(rst), .master_sel(master_sel),
        .go_start(go_start), .go_stop(go_stop), .list_addr(list_addr), .own_addr(own_addr),
        .dma_req_valid(dma_req_valid), .dma_req_ready(dma_req_ready),
        .dma_req_addr(dma_req_addr), .dma_rsp_valid(dma_rsp_valid),
        .dma_rsp_data(dma_rsp_data), .bus_tx_valid(bus_tx_valid), .bus_tx_ready(bus_tx_ready),
        .bus_tx_word(bus_tx_word), .bus_rx_valid(bus_rx_valid), .bus_rx_ready(bus_rx_ready),
        .bus_rx_word(bus_rx_word), .proc_rx_valid(proc_rx_valid), .proc_rx_ready(1'b1),
        .proc_rx_data(proc_rx_data), .proc_tx_valid(1'b0), .proc_tx_ready(proc_tx_ready),
        .proc_tx_data(16'h0000), .isw_clr(isw_clr),
        .internal_status_word(internal_status_word), .irq_lvl1(irq_lvl1), .running(running));
    dbmis_dma_mem i_dbmis_dma_mem (.core_clk(core_clk), .rst(rst),
        .dma_req_valid(dma_req_valid), .dma_req_ready(dma_req_ready),
        .dma_req_addr(dma_req_addr), .dma_rsp_valid(dma_rsp_valid),
        .dma_rsp_data(dma_rsp_data), .lat(lat));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // A hung handshake must not stall the run forever.
    always @(posedge core_clk) begin
        cyc++;
        if (bus_tx_valid !== 2'h0 && master_sel) tx_seen = 1'b1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic start(input logic ms, input logic [15:0] a);
        master_sel = ms;
        list_addr = a;
        go_start = 1'b1;
        step(1);
        go_start = 1'b0;
        chk("running", 17'h1, running);
    endtask : start
    task automatic finish_list(input logic [15:0] exp_isw);
        for (int n = 0; n < 3000 && running !== 1'b0; n++) step(1);
        chk("halted", 17'h0, running);
        chk("status", exp_isw, internal_status_word);
        chk("irq", 17'h1, irq_lvl1);
        isw_clr = 16'hFFFF;
        step(1);
        isw_clr = 16'h0000;
        chk("cleared", 17'h0, internal_status_word);
    endtask : finish_list
    task automatic test_link_halt();
        i_dbmis_dma_mem.mem[16] = 16'h4563;
        i_dbmis_dma_mem.mem[17] = 16'h0040;
        i_dbmis_dma_mem.mem[64] = 16'h0000;
        i_dbmis_dma_mem.mem[65] = 16'h0000;
        lat = 4'h3;
        start(1'b1, 16'h0010);
        finish_list(16'h0003);
        step(20);
        chk("fetches", 17'h4, i_dbmis_dma_mem.addr_log.size());
        chk("link target", 17'h40, i_dbmis_dma_mem.addr_log[2]);
        chk("pair second", 17'h41, i_dbmis_dma_mem.addr_log[3]);
    endtask : test_link_halt
    task automatic test_nop_sameaddr();
        i_dbmis_dma_mem.mem[32] = 16'h8000;
        i_dbmis_dma_mem.mem[33] = 16'h0000;
        i_dbmis_dma_mem.mem[34] = 16'hC061;
        i_dbmis_dma_mem.mem[35] = 16'h0062;
        i_dbmis_dma_mem.mem[36] = 16'h0000;
        i_dbmis_dma_mem.mem[37] = 16'h0000;
        lat = 4'h0;
        tx_seen = 1'b0;
        start(1'b1, 16'h0020);
        finish_list(16'h0005);
        chk("no bus traffic", 17'h0, tx_seen);
    endtask : test_nop_sameaddr
    task automatic test_no_reply();
        i_dbmis_dma_mem.mem[62] = 16'hC0A1;
        i_dbmis_dma_mem.mem[63] = 16'h0862;
        bus_tx_ready = 2'h1;
        start(1'b1, 16'h003E);
        while (bus_tx_valid[0] !== 1'b1) step(1);
        chk("tx cmd", {1'b1, 16'h1C41}, bus_tx_word[0]);
        step(1);
        bus_tx_ready = 2'h0;
        finish_list(16'h0009);
    endtask : test_no_reply
    task automatic test_remote_mode();
        start(1'b0, 16'h0000);
        bus_rx_word[1] = {1'b1, 16'h2C00};
        bus_rx_valid = 2'h2;
        do @(posedge core_clk); while (bus_rx_ready[1] !== 1'b1);
        #1;
        bus_rx_valid = 2'h0;
        bus_rx_word[1] = {1'b0, 16'hD3FF};
        for (int n = 0; n < 200 && bus_tx_valid[1] !== 1'b1; n++) step(1);
        chk("reply bus", 17'h2, bus_tx_valid);
        chk("reply word", {1'b1, 16'h2800}, bus_tx_word[1]);
        bus_tx_ready = 2'h2;
        step(1);
        bus_tx_ready = 2'h0;
        step(3);
        chk("special", 17'h40, internal_status_word);
        go_stop = 1'b1;
        step(1);
        go_stop = 1'b0;
        step(1);
        chk("stopped", 17'h0, running);
    endtask : test_remote_mode
    initial begin
        rst = 1'b1;
        {master_sel, go_start, go_stop, tx_seen} = 4'h0;
        list_addr = 16'h0000;
        own_addr = 5'h05;
        isw_clr = 16'h0000;
        lat = 4'h0;
        bus_tx_ready = 2'h0;
        bus_rx_valid = 2'h0;
        bus_rx_word = '0;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk("reset status", 17'h0, internal_status_word);
        chk("reset run", 17'h0, running);
        test_link_halt();
        test_nop_sameaddr();
        test_no_reply();
        test_remote_mode();
        print_verdict();
    end
endmodule : test_dual_bus_master_instruction_sequencer
`default_nettype wire
